// [hdl/ebm_clkdiv.sv]
// Bus clock divider with a mode-dependent ratio
`timescale 1ns/100ps
module ebm_clkdiv #(
    parameter int DIV_W = 2
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    // Control
    input  wire logic             half_i,
    // Bus clock
    output logic                  bclk_o,
    output logic                  rise_o
);
    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] cnt_nxt;
    logic             bclk_r;
    logic             bclk_nxt;

    // Divide by two or by four
    always_comb begin
        cnt_nxt  = cnt_r + 1'b1;
        if (half_i) begin
            bclk_nxt = ~bclk_r;
        end else begin
            bclk_nxt = cnt_nxt[1];
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r  <= '0;
            bclk_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            bclk_r <= bclk_nxt;
        end
    end

    assign bclk_o = bclk_r;
    assign rise_o = bclk_nxt & ~bclk_r;
endmodule

// [hdl/ebm_pkg.sv]
// Package with the constants of the external bus pin mapper
package ebm_pkg;
    // Bus configurations
    typedef enum logic [1:0] {
        EBM_MODE_N16 = 2'b00,   // 16-bit, separate address and data
        EBM_MODE_M16 = 2'b01,   // 16-bit, address and data share pins
        EBM_MODE_M32 = 2'b10    // 32-bit, address and data share pins
    } ebm_mode_t;

    // Access phases
    typedef enum logic [1:0] {
        EBM_ST_IDLE = 2'b00,
        EBM_ST_ADDR = 2'b01,
        EBM_ST_DATA = 2'b10
    } ebm_state_t;

    // Pad function codes
    localparam logic [1:0] PAD_PRIMARY = 2'h0;
    localparam logic [1:0] PAD_ALT1    = 2'h1;
    localparam logic [1:0] PAD_ALT2    = 2'h2;

    // Bus clock ratios against the system clock
    localparam int RATIO_N16 = 4;
    localparam int RATIO_M16 = 2;
    localparam int RATIO_M32 = 4;

    // Reset values
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [1:0]  DIV_RST  = 2'h0;
endpackage

// [hdl/ebm_top.sv]
// External bus pin mapper: mode select, pin sharing and bus clock
// Notes on behaviour
// - Three configurations: N16, shared M16, shared M32
// - Bus clock quarter, or half in M16
// - N16 keeps legacy pins, no latch strobe
// - Chip select, OE, direction never move
// - Shared mode: low address on data lane
// - M32: upper data on low address pins
// - Shared modes: latch strobe on start pin
// - Shared modes: start moves to acknowledge pin
`timescale 1ns/100ps
module ebm_top (
    // Clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        RESET_N_I,
    // Configuration
    input  wire logic        ADDR_DATA_SHARE_ENABLE_I,
    input  wire logic        PORT_SIZE_SELECT_I,
    input  wire logic [1:0]  PAD_FUNCTION_SELECT_I,
    // Internal master request
    input  wire logic        REQ_I,
    input  wire logic        WRITE_I,
    input  wire logic [31:0] ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic [3:0]  BYTE_EN_I,
    input  wire logic        DONE_I,
    // Status
    output logic [1:0]       MODE_O,
    output logic             BUS_CLK_O,
    output logic             BUSY_O,
    // Fixed pins
    output logic             CS_N_O,
    output logic             OE_N_O,
    output logic             RD_WR_O,
    // Low address pins, shared with upper data in M32
    output logic [15:0]      ADDR_LO_O,
    output logic             ADDR_LO_OE_O,
    // Data lane, shared with low address in shared modes
    output logic [15:0]      DATA_O,
    output logic             DATA_OE_O,
    // Byte write strobes
    output logic [1:0]       WE_LO_N_O,
    output logic [1:0]       WE_HI_N_O,
    // Start pin and acknowledge pin
    output logic             START_PIN_O,
    output logic             START_PIN_OE_O,
    output logic             ACK_PIN_O,
    output logic             ACK_PIN_OE_O
);
    ebm_pkg::ebm_mode_t  mode;
    ebm_pkg::ebm_state_t st_r;
    ebm_pkg::ebm_state_t st_nxt;
    logic [15:0] alo_r;
    logic [15:0] alo_nxt;
    logic [15:0] dat_r;
    logic [15:0] dat_nxt;
    logic        doe_r;
    logic        doe_nxt;
    logic        aoe_r;
    logic        aoe_nxt;
    logic        ts_r;
    logic        ts_nxt;
    logic        ale_r;
    logic        ale_nxt;
    logic        act_r;
    logic        act_nxt;
    logic        bclk;
    logic        brise;
    logic        shared;

    // Mode decode from share enable, port size and pad function
    function automatic ebm_pkg::ebm_mode_t decode_mode(input logic sh, input logic ps,
                                                       input logic [1:0] pa);
        if (!sh) begin
            return ebm_pkg::EBM_MODE_N16;
        end else if (!ps && pa == ebm_pkg::PAD_ALT2) begin
            return ebm_pkg::EBM_MODE_M32;
        end else begin
            return ebm_pkg::EBM_MODE_M16;
        end
    endfunction

    assign mode   = decode_mode(ADDR_DATA_SHARE_ENABLE_I, PORT_SIZE_SELECT_I,
                                PAD_FUNCTION_SELECT_I);
    assign shared = (mode != ebm_pkg::EBM_MODE_N16);

    // Bus clock, half rate only in M16
    ebm_clkdiv #(
        .DIV_W (2)
    ) u_div (
        .clk_i     (CLK_SYS_I),
        .reset_n_i (RESET_N_I),
        .half_i    (mode == ebm_pkg::EBM_MODE_M16),
        .bclk_o    (bclk),
        .rise_o    (brise)
    );

    // Access sequencing and pin values
    always_comb begin
        st_nxt  = st_r;
        alo_nxt = alo_r;
        dat_nxt = dat_r;
        doe_nxt = doe_r;
        aoe_nxt = aoe_r;
        ts_nxt  = 1'b0;
        ale_nxt = ale_r;
        act_nxt = act_r;
        unique case (st_r)
            ebm_pkg::EBM_ST_IDLE: begin
                doe_nxt = 1'b0;
                aoe_nxt = 1'b0;
                act_nxt = 1'b0;
                if (REQ_I && brise) begin
                    st_nxt  = shared ? ebm_pkg::EBM_ST_ADDR : ebm_pkg::EBM_ST_DATA;
                    act_nxt = 1'b1;
                    ts_nxt  = 1'b1;
                    aoe_nxt = 1'b1;
                    alo_nxt = ADDR_I[15:0];
                    if (shared) begin
                        dat_nxt = ADDR_I[15:0];
                        doe_nxt = 1'b1;
                        ale_nxt = 1'b1;
                    end else begin
                        dat_nxt = WDATA_I[15:0];
                        doe_nxt = WRITE_I;
                    end
                end
            end
            ebm_pkg::EBM_ST_ADDR: begin
                if (brise) begin
                    st_nxt  = ebm_pkg::EBM_ST_DATA;
                    ale_nxt = 1'b0;
                    dat_nxt = WDATA_I[15:0];
                    doe_nxt = WRITE_I;
                    if (mode == ebm_pkg::EBM_MODE_M32) begin
                        alo_nxt = WDATA_I[31:16];
                        aoe_nxt = WRITE_I;
                    end
                end
            end
            ebm_pkg::EBM_ST_DATA: begin
                if (DONE_I) begin
                    st_nxt  = ebm_pkg::EBM_ST_IDLE;
                    act_nxt = 1'b0;
                    doe_nxt = 1'b0;
                    aoe_nxt = 1'b0;
                end
            end
            default: st_nxt = ebm_pkg::EBM_ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            st_r  <= ebm_pkg::EBM_ST_IDLE;
            alo_r <= ebm_pkg::DATA_RST;
            dat_r <= ebm_pkg::DATA_RST;
            doe_r <= 1'b0;
            aoe_r <= 1'b0;
            ts_r  <= 1'b0;
            ale_r <= 1'b0;
            act_r <= 1'b0;
        end else begin
            st_r  <= st_nxt;
            alo_r <= alo_nxt;
            dat_r <= dat_nxt;
            doe_r <= doe_nxt;
            aoe_r <= aoe_nxt;
            ts_r  <= ts_nxt;
            ale_r <= ale_nxt;
            act_r <= act_nxt;
        end
    end

    // Fixed pins stay put in every mode
    assign CS_N_O  = ~act_r;
    assign OE_N_O  = ~(act_r & ~WRITE_I & (st_r == ebm_pkg::EBM_ST_DATA));
    assign RD_WR_O = ~(act_r & WRITE_I);

    // Moving pins
    assign ADDR_LO_O    = alo_r;
    assign ADDR_LO_OE_O = aoe_r;
    assign DATA_O       = dat_r;
    assign DATA_OE_O    = doe_r;
    assign WE_LO_N_O    = ~({2{act_r & WRITE_I & (st_r == ebm_pkg::EBM_ST_DATA)}}
                            & BYTE_EN_I[1:0]);
    assign WE_HI_N_O    = ~({2{act_r & WRITE_I & (st_r == ebm_pkg::EBM_ST_DATA)
                               & (mode == ebm_pkg::EBM_MODE_M32)}} & BYTE_EN_I[3:2]);
    // Start pin carries latch strobe in shared modes, start otherwise
    assign START_PIN_O    = shared ? ale_r : ts_r;
    assign START_PIN_OE_O = 1'b1;
    // Acknowledge pin carries start in shared modes, input otherwise
    assign ACK_PIN_O      = shared ? ts_r : 1'b0;
    assign ACK_PIN_OE_O   = shared;

    assign MODE_O    = mode;
    assign BUS_CLK_O = bclk;
    assign BUSY_O    = act_r;

    // Checks: the start pin pulses only as an access opens in N16
    a_n16_no_latch: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (mode == ebm_pkg::EBM_MODE_N16) && START_PIN_O |-> $rose(BUSY_O))
        else $error("start pin high outside access start in N16");
    a_addr_on_lane: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (st_r == ebm_pkg::EBM_ST_ADDR) |-> DATA_OE_O && START_PIN_O)
        else $error("address phase without address on lane");
    a_ack_pin_start: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        $rose(BUSY_O) |-> ACK_PIN_OE_O == shared && ACK_PIN_O == shared)
        else $error("start not on acknowledge pin");
    a_cs_follows: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        $rose(BUSY_O) |-> !CS_N_O ##0 $past(REQ_I))
        else $error("chip select without request");
    // A stable M16 mode over the last cycle means the bus clock toggled at it
    a_m16_half: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (mode == ebm_pkg::EBM_MODE_M16) && $stable(mode)
        |-> BUS_CLK_O != $past(BUS_CLK_O))
        else $error("bus clock not half rate");
    // Upper write data lands on the low address pins as the data phase opens
    a_m32_upper_lane: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (mode == ebm_pkg::EBM_MODE_M32) && (st_r == ebm_pkg::EBM_ST_DATA)
        && ($past(st_r) == ebm_pkg::EBM_ST_ADDR) && $past(WRITE_I)
        |-> ADDR_LO_O == $past(WDATA_I[31:16]) && ADDR_LO_OE_O)
        else $error("upper data missing on low address pins");
    c_n16: cover property (@(posedge CLK_SYS_I) mode == ebm_pkg::EBM_MODE_N16 && $rose(BUSY_O));
    c_m16: cover property (@(posedge CLK_SYS_I) mode == ebm_pkg::EBM_MODE_M16 && $rose(BUSY_O));
    c_m32: cover property (@(posedge CLK_SYS_I) mode == ebm_pkg::EBM_MODE_M32 && $rose(BUSY_O));
endmodule

// [tb/ebm_mem_model.sv]
// Far side memory behind an address latch, with a settable completion delay
`timescale 1ns/100ps
module ebm_mem_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Pins from the mapper, and the settable wait count
    input  wire logic [1:0]  mode_i,
    input  wire logic        cs_n_i,
    input  wire logic        strobe_i,
    input  wire logic [15:0] addr_lo_i,
    input  wire logic [15:0] data_i,
    input  wire logic [3:0]  wait_i,
    // Latched address, captured data, completion
    output logic [15:0]      lat_addr_o,
    output logic [31:0]      cap_data_o,
    output logic             done_o
);
    logic [4:0] cnt_r;

    // Latch address on the strobe, then finish after a fixed plus settable delay
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= 5'h00;
            done_o <= 1'b0;
            lat_addr_o <= 16'h0000;
            cap_data_o <= 32'h0000_0000;
        end else begin
            done_o <= 1'b0;
            cnt_r <= cs_n_i ? 5'h00 : cnt_r + 5'h01;
            if (!cs_n_i && strobe_i) begin
                lat_addr_o <= (mode_i == ebm_pkg::EBM_MODE_N16) ? addr_lo_i : data_i;
            end
            if (!cs_n_i && cnt_r == 5'h0C + {1'b0, wait_i}) begin
                done_o <= 1'b1;
                cap_data_o <= {addr_lo_i, data_i};
            end
        end
    end
endmodule

// [tb/tb_top.sv]
// Self-checking bench of the external bus pin mapper
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    logic        clk, rst_n, share, ps, req, wr, done;
    logic [1:0]  pa, mode_o, we_lo, we_hi;
    logic [3:0]  be, wt;
    logic [31:0] addr, wdata, cap;
    logic [31:0] seed = 32'h312f_7d7c;
    logic [15:0] addr_lo, data, lat;
    logic        bclk, busy, cs_n, oe_n, rdwr, alo_oe, data_oe, st, st_oe, ack, ack_oe;
    int          fail_count = 0;
    int          total_checks = 0;
    int          cyc = 0;

    ebm_top dut (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .ADDR_DATA_SHARE_ENABLE_I(share),
        .PORT_SIZE_SELECT_I(ps), .PAD_FUNCTION_SELECT_I(pa), .REQ_I(req), .WRITE_I(wr),
        .ADDR_I(addr), .WDATA_I(wdata), .BYTE_EN_I(be), .DONE_I(done), .MODE_O(mode_o),
        .BUS_CLK_O(bclk), .BUSY_O(busy), .CS_N_O(cs_n), .OE_N_O(oe_n), .RD_WR_O(rdwr),
        .ADDR_LO_O(addr_lo), .ADDR_LO_OE_O(alo_oe), .DATA_O(data), .DATA_OE_O(data_oe),
        .WE_LO_N_O(we_lo), .WE_HI_N_O(we_hi), .START_PIN_O(st), .START_PIN_OE_O(st_oe),
        .ACK_PIN_O(ack), .ACK_PIN_OE_O(ack_oe));
    ebm_mem_model mem (.clk_i(clk), .reset_n_i(rst_n), .mode_i(mode_o), .cs_n_i(cs_n),
        .strobe_i(st), .addr_lo_i(addr_lo), .data_i(data), .wait_i(wt),
        .lat_addr_o(lat), .cap_data_o(cap), .done_o(done));

    // Pseudo-random source
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Expected configuration from the three selects
    function automatic logic [1:0] exp_mode(input logic s, input logic p, input logic [1:0] a);
        if (!s) return ebm_pkg::EBM_MODE_N16;
        return (!p && a == ebm_pkg::PAD_ALT2) ? ebm_pkg::EBM_MODE_M32 : ebm_pkg::EBM_MODE_M16;
    endfunction
    // Expected bus clock ratio
    function automatic int exp_ratio(input logic [1:0] m);
        if (m == ebm_pkg::EBM_MODE_M16) return ebm_pkg::RATIO_M16;
        return (m == ebm_pkg::EBM_MODE_M32) ? ebm_pkg::RATIO_M32 : ebm_pkg::RATIO_N16;
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Change the selects while idle and let them settle
    task automatic set_mode(input logic s, input logic p, input logic [1:0] a);
        @(posedge clk);
        share <= s;
        ps <= p;
        pa <= a;
        @(posedge clk);
        #1;
    endtask

    // Measure cycles between bus clock rises
    task automatic chk_clk();
        logic p;
        int   n, k;
        k = 0;
        n = 0;
        p = bclk;
        repeat (24) begin
            @(posedge clk);
            #1;
            n++;
            if (bclk && !p) begin
                if (k > 0) `CHK(n, exp_ratio(exp_mode(share, ps, pa)))
                k++;
                n = 0;
            end
            p = bclk;
        end
    endtask

    // One access with a random address, data and direction
    task automatic access(input logic [3:0] w_c);
        int         i;
        logic [1:0] md;
        logic       sh;
        md = exp_mode(share, ps, pa);
        sh = (md != ebm_pkg::EBM_MODE_N16);
        seed = lfsr(seed);
        @(posedge clk);
        req <= 1'b1;
        wr <= seed[4];
        addr <= seed;
        wdata <= ~{seed[15:0], seed[31:16]};
        be <= seed[11:8];
        wt <= w_c;
        i = 0;
        do begin @(posedge clk); #1; i++; end while (busy !== 1'b1 && i < 10);
        `CHK(busy, 1'b1)
        `CHK(cs_n, 1'b0)
        `CHK(rdwr, ~wr)
        `CHK(st, 1'b1)
        `CHK(st_oe, 1'b1)
        `CHK(ack_oe, sh)
        `CHK(ack, sh)
        `CHK(alo_oe, 1'b1)
        `CHK(oe_n, sh | wr)
        `CHK(we_lo, (!sh && wr) ? ~be[1:0] : 2'b11)
        `CHK(we_hi, 2'b11)
        if (!sh) `CHK(addr_lo, addr[15:0])
        else `CHK(data, addr[15:0])
        i = 0;
        do begin @(posedge clk); #1; i++; end while (done !== 1'b1 && i < 60);
        `CHK(done, 1'b1)
        // Data phase still stands while the completion pulse waits to be taken
        `CHK(st, 1'b0)
        `CHK(ack, 1'b0)
        `CHK(oe_n, wr)
        `CHK(data_oe, wr)
        `CHK(we_lo, wr ? ~be[1:0] : 2'b11)
        `CHK(we_hi, (wr && md == ebm_pkg::EBM_MODE_M32) ? ~be[3:2] : 2'b11)
        `CHK(alo_oe, (md == ebm_pkg::EBM_MODE_M32) ? wr : 1'b1)
        @(posedge clk);
        req <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK(busy, 1'b0)
        `CHK(cs_n, 1'b1)
        `CHK(lat, addr[15:0])
        if (wr) `CHK(cap[15:0], wdata[15:0])
        if (wr && md == ebm_pkg::EBM_MODE_M32) `CHK(cap[31:16], wdata[31:16])
    endtask

    // System clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        {share, ps, pa, req, wr, be, wt} = 14'h0000;
        addr = 32'h0000_0000;
        wdata = 32'h0000_0000;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        `CHK(cs_n, 1'b1)
        `CHK(data_oe, 1'b0)
        for (int c = 0; c < 16; c++) begin
            set_mode(c[3], c[2], c[1:0]);
            `CHK(mode_o, exp_mode(share, ps, pa))
        end
        for (int m = 0; m < 3; m++) begin
            set_mode(m != 0, m != 2, (m == 2) ? ebm_pkg::PAD_ALT2 : ebm_pkg::PAD_PRIMARY);
            chk_clk();
            for (int k = 0; k < 6; k++) begin
                seed = lfsr(seed);
                access((k == 0) ? 4'h0 : ((k == 1) ? 4'hF : seed[3:0]));
            end
        end
        report_and_stop();
    end
endmodule
